// File: verilog/qax_exec.sv
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module qax_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic [14:0]      mem_addr,
  output logic [23:0]      mem_wdata,
  input  wire logic [23:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             busy
);

  // ****************************************
  // Functions
  // ****************************************

  // One's complement add with end-around carry
  function automatic logic [23:0] oc_add(input logic [23:0] a,
                                         input logic [23:0] b);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[23:0] + {23'h0, s[24]};
  endfunction

  // Circular left rotate of a 24-bit word
  function automatic logic [23:0] rotl(input logic [23:0] w,
                                       input logic [5:0] n);
    logic [47:0] d;
    logic [5:0]  k;
    k = n % 6'd24;
    d = {w, w} << k;
    return d[47:24];
  endfunction

  // Selected portion, right aligned
  function automatic logic [23:0] portion(input logic [23:0] w,
                                          input logic [2:0] m);
    portion = w;
    case (m)
      qax_pkg::M_LOW:  portion = {16'h0000, w[7:0]};
      qax_pkg::M_MID:  portion = {16'h0000, w[15:8]};
      qax_pkg::M_HIGH: portion = {16'h0000, w[23:16]};
      default:         portion = w;
    endcase
  endfunction

  // Only the selected third changes; others keep memory
  function automatic logic [23:0] merge(input logic [23:0] w,
                                        input logic [7:0] v,
                                        input logic [2:0] m);
    merge = w;
    case (m)
      qax_pkg::M_LOW:  merge[7:0] = v;
      qax_pkg::M_MID:  merge[15:8] = v;
      qax_pkg::M_HIGH: merge[23:16] = v;
      default:         merge = w;
    endcase
  endfunction

  // Rotation time grows 4 us per four extra positions
  function automatic logic [11:0] rot_time(input logic [5:0] n);
    logic [5:0] d;
    d = n - 6'd12;
    if (n >= 6'd12) begin
      rot_time = qax_pkg::C_ROT_LONG + C_ROT_STEP_X(d);
    end else if (n == 6'd3 || n == 6'd7 || n == 6'd11) begin
      rot_time = qax_pkg::C_ROT_LONG;
    end else begin
      rot_time = qax_pkg::C_ROT;
    end
  endfunction

  function automatic logic [11:0] C_ROT_STEP_X(input logic [5:0] d);
    return qax_pkg::C_ROT_STEP * {8'h00, d[5:2]};
  endfunction

  function automatic logic op_legal(input logic [5:0] o);
    return o == qax_pkg::OP_LOAD || o == qax_pkg::OP_STORE ||
           o == qax_pkg::OP_COMP || o == qax_pkg::OP_ROT ||
           o == qax_pkg::OP_COPY || o == qax_pkg::OP_JUMP ||
           o == qax_pkg::OP_ADDC || o == qax_pkg::OP_ADD ||
           o == qax_pkg::OP_ADR;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == qax_pkg::A_CMD || a == qax_pkg::A_STAT ||
           a == qax_pkg::A_ACC || a == qax_pkg::A_EXT ||
           a == qax_pkg::A_PC || a == qax_pkg::A_CTRL ||
           (a > qax_pkg::A_IDX && a < 8'h40 && a[1:0] == 2'b00);
  endfunction

  // ****************************************
  // State and fields
  // ****************************************

  qax_pkg::qax_state_e state;
  logic [23:0] acc;
  logic [23:0] ext;
  logic [14:0] pc;
  logic        trace;
  logic [14:0] idx [1:7];
  logic [31:0] cmd;
  logic [4:0]  rep_left;
  logic        first;
  logic [14:0] addr;
  logic [11:0] timer;
  logic        last_jump;

  logic [5:0]  op;
  logic [2:0]  msel;
  logic        wr_en;
  logic        start_cmd;
  logic [2:0]  new_b;
  logic [14:0] new_y;
  logic [14:0] new_eff;
  logic        jcond;
  logic        jret;
  logic [14:0] jtgt;
  logic [11:0] step_time;
  logic        step_end;

  assign op = cmd[qax_pkg::OP_LSB +: 6];
  assign msel = cmd[qax_pkg::M_LSB +: 3];
  assign wr_en = psel && penable && pwrite;
  assign start_cmd = wr_en && paddr == qax_pkg::A_CMD &&
                     state == qax_pkg::S_IDLE &&
                     op_legal(pwdata[qax_pkg::OP_LSB +: 6]);
  assign new_b = pwdata[qax_pkg::B_LSB +: 3];
  assign new_y = pwdata[qax_pkg::Y_LSB +: 15];

  // Field plus chosen index register
  assign new_eff = (new_b != 3'h0) ? new_y + idx[new_b] : new_y;

  // Sign test: even selector wants positive, odd negative
  assign jcond = msel[0] ? ext[23] : !ext[23];
  assign jret = msel[2] || trace;
  assign jtgt = trace ? 15'h0000 : addr;
  assign step_end = state == qax_pkg::S_WAIT && timer <= 12'd1;
  assign busy = state != qax_pkg::S_IDLE;

  // Step time chosen at dispatch
  always_comb begin
    step_time = qax_pkg::C_XFER;
    unique case (op)
      qax_pkg::OP_LOAD, qax_pkg::OP_STORE, qax_pkg::OP_ADD: begin
        step_time = first ? qax_pkg::C_MEM : qax_pkg::C_MEM_REP;
      end
      qax_pkg::OP_COMP: begin
        step_time = first ? qax_pkg::C_COMP : qax_pkg::C_COMP_REP;
      end
      qax_pkg::OP_COPY, qax_pkg::OP_ADDC: begin
        step_time = first ? qax_pkg::C_XFER : qax_pkg::C_XFER_REP;
      end
      qax_pkg::OP_ROT: begin
        step_time = rot_time(addr[5:0]);
      end
      qax_pkg::OP_JUMP: begin
        if (!jcond) begin
          step_time = first ? qax_pkg::C_MEM : qax_pkg::C_MEM_REP;
        end else begin
          step_time = jret ? qax_pkg::C_JRET : qax_pkg::C_MEM;
        end
      end
      qax_pkg::OP_ADR: begin
        step_time = first ? qax_pkg::C_ADR : qax_pkg::C_ADR_REP;
      end
      default: step_time = qax_pkg::C_XFER;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************

  // Memory slower than the step time simply stretches the step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= qax_pkg::S_IDLE;
    end else begin
      unique case (state)
        qax_pkg::S_IDLE: begin
          if (start_cmd) begin
            state <= qax_pkg::S_DISP;
          end
        end
        qax_pkg::S_DISP: begin
          if (op == qax_pkg::OP_LOAD || op == qax_pkg::OP_ADD ||
              op == qax_pkg::OP_ADR) begin
            state <= qax_pkg::S_RD;
          end else if (op == qax_pkg::OP_STORE) begin
            // Partial store needs the old word first
            state <= (msel == 3'h0 || msel > qax_pkg::M_HIGH) ?
                     qax_pkg::S_WR : qax_pkg::S_RD;
          end else if (op == qax_pkg::OP_JUMP && jcond && jret) begin
            state <= qax_pkg::S_WR;
          end else begin
            state <= qax_pkg::S_WAIT;
          end
        end
        qax_pkg::S_RD: begin
          if (mem_ack) begin
            state <= (op == qax_pkg::OP_STORE || op == qax_pkg::OP_ADR) ?
                     qax_pkg::S_WR : qax_pkg::S_WAIT;
          end
        end
        qax_pkg::S_WR: begin
          if (mem_ack) begin
            state <= qax_pkg::S_WAIT;
          end
        end
        qax_pkg::S_WAIT: begin
          if (step_end) begin
            state <= (rep_left != 5'h00) ? qax_pkg::S_DISP : qax_pkg::S_IDLE;
          end
        end
        default: state <= qax_pkg::S_IDLE;
      endcase
    end
  end

  // Command latch, repeat count and operand address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= 32'h00000000;
      rep_left <= 5'h00;
      first <= 1'b0;
      addr <= qax_pkg::RST_PC;
    end else if (start_cmd) begin
      cmd <= pwdata;
      // Copy has no repeat
      rep_left <= (pwdata[qax_pkg::OP_LSB +: 6] == qax_pkg::OP_COPY) ?
                  5'h00 : pwdata[qax_pkg::R_LSB +: 5];
      first <= 1'b1;
      addr <= new_eff;
    end else if (state == qax_pkg::S_DISP && op == qax_pkg::OP_JUMP &&
                 jcond) begin
      rep_left <= 5'h00;
    end else if (step_end && rep_left != 5'h00) begin
      rep_left <= rep_left - 5'h01;
      first <= 1'b0;
      if (op == qax_pkg::OP_LOAD || op == qax_pkg::OP_STORE ||
          op == qax_pkg::OP_ADD || op == qax_pkg::OP_ADR) begin
        addr <= addr + 15'h0001;
      end
    end
  end

  // Step timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= 12'h000;
    end else if (state == qax_pkg::S_DISP) begin
      timer <= step_time - 12'h001;
    end else if (timer != 12'h000) begin
      timer <= timer - 12'h001;
    end
  end

  // ****************************************
  // Datapath
  // ****************************************

  // Software writes only land while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= qax_pkg::RST_WORD;
      ext <= qax_pkg::RST_WORD;
      pc <= qax_pkg::RST_PC;
    end else if (state == qax_pkg::S_IDLE) begin
      if (wr_en && paddr == qax_pkg::A_ACC) begin
        acc <= pwdata[23:0];
      end
      if (wr_en && paddr == qax_pkg::A_EXT) begin
        ext <= pwdata[23:0];
      end
      if (wr_en && paddr == qax_pkg::A_PC) begin
        pc <= pwdata[14:0];
      end
    end else if (state == qax_pkg::S_DISP) begin
      unique case (op)
        qax_pkg::OP_COMP: ext <= ~ext;
        qax_pkg::OP_ROT: ext <= rotl(ext, addr[5:0]);
        qax_pkg::OP_COPY: ext <= acc;
        qax_pkg::OP_ADDC: acc <= oc_add(acc, {9'h000, addr});
        qax_pkg::OP_JUMP: begin
          if (!msel[1]) begin
            ext <= rotl(ext, 6'd1);
          end
          if (jcond) begin
            pc <= jret ? jtgt + 15'h0001 : jtgt;
          end
        end
        default: acc <= acc;
      endcase
    end else if (state == qax_pkg::S_RD && mem_ack) begin
      unique case (op)
        qax_pkg::OP_LOAD: ext <= portion(mem_rdata, msel);
        qax_pkg::OP_ADD: acc <= oc_add(acc, portion(mem_rdata, msel));
        qax_pkg::OP_ADR: acc <= oc_add(acc, mem_rdata);
        default: ext <= ext;
      endcase
    end
  end

  // Memory address and write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 15'h0000;
      mem_wdata <= qax_pkg::RST_WORD;
    end else if (state == qax_pkg::S_DISP) begin
      mem_addr <= (op == qax_pkg::OP_JUMP) ? jtgt : addr;
      // Whole store, or saved continuation for a return jump
      mem_wdata <= (op == qax_pkg::OP_JUMP) ? {9'h000, pc} : ext;
    end else if (state == qax_pkg::S_RD && mem_ack) begin
      mem_wdata <= (op == qax_pkg::OP_ADR) ? oc_add(acc, mem_rdata) :
                   merge(mem_rdata, ext[7:0], msel);
    end
  end

  assign mem_req = state == qax_pkg::S_RD || state == qax_pkg::S_WR;
  assign mem_we = state == qax_pkg::S_WR;

  // Jump outcome kept for status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_jump <= 1'b0;
    end else if (start_cmd) begin
      last_jump <= 1'b0;
    end else if (state == qax_pkg::S_DISP && op == qax_pkg::OP_JUMP) begin
      last_jump <= jcond;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************

  // Trace and index registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace <= 1'b0;
      for (int i = 1; i < 8; i++) begin
        idx[i] <= 15'h0000;
      end
    end else if (wr_en) begin
      if (paddr == qax_pkg::A_CTRL) begin
        trace <= pwdata[0];
      end
      for (int i = 1; i < 8; i++) begin
        if (paddr == qax_pkg::A_IDX + 8'(4 * i) && !busy) begin
          idx[i] <= pwdata[14:0];
        end
      end
    end
  end

  // Read data loaded in setup so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      case (paddr)
        qax_pkg::A_CMD:  prdata <= cmd;
        qax_pkg::A_STAT: prdata <= {30'h00000000, last_jump, busy};
        qax_pkg::A_ACC:  prdata <= {8'h00, acc};
        qax_pkg::A_EXT:  prdata <= {8'h00, ext};
        qax_pkg::A_PC:   prdata <= {17'h00000, pc};
        qax_pkg::A_CTRL: prdata <= {31'h00000000, trace};
        default: begin
          if (mapped(paddr)) begin
            prdata <= {17'h00000, idx[paddr[4:2]]};
          end
        end
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // ****************************************
  // Checks
  // ****************************************

  property p_comp;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_COMP |=> ext == ~$past(ext);
  endproperty
  a_comp: assert property (p_comp) else $error("complement wrong");

  property p_negzero;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_COMP && ext == 24'h000000
    |=> ext == 24'hffffff;
  endproperty
  a_negzero: assert property (p_negzero) else $error("no negative zero");

  property p_store_keep;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_WR && op == qax_pkg::OP_STORE |=> $stable(ext);
  endproperty
  a_store_keep: assert property (p_store_keep) else $error("store moved ext");

  property p_third;
    @(posedge pclk) disable iff (!presetn)
    mem_we && op == qax_pkg::OP_STORE && msel == qax_pkg::M_MID
    |-> mem_wdata[15:8] == ext[7:0];
  endproperty
  a_third: assert property (p_third) else $error("third not stored");

  property p_copy;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_COPY
    |=> ext == $past(acc) && $stable(acc) ##1 $stable(ext);
  endproperty
  a_copy: assert property (p_copy) else $error("copy wrong");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_JUMP && msel[1] |=> $stable(ext);
  endproperty
  a_hold: assert property (p_hold) else $error("ext shifted");

  property p_trace;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_JUMP && jcond && trace
    |=> pc == 15'h0001 ##[1:3] (mem_we && mem_addr == 15'h0000);
  endproperty
  a_trace: assert property (p_trace) else $error("trace jump wrong");

  property p_rep_end;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_JUMP && jcond
    |=> rep_left == 5'h00;
  endproperty
  a_rep_end: assert property (p_rep_end) else $error("repeat not ended");

  property p_load_time;
    @(posedge pclk) disable iff (!presetn)
    state == qax_pkg::S_DISP && op == qax_pkg::OP_LOAD && first
    |=> timer == qax_pkg::C_MEM - 12'h001;
  endproperty
  a_load_time: assert property (p_load_time) else $error("load time wrong");

endmodule
`default_nettype wire

// File: shared/qax_pkg.sv
// Functional notes
// - Opcode 22 loads extension from word at address plus index, portion selected.
// - Opcode 23 stores extension into addressed word; extension keeps its value.
// - Store alters only the selected portion; bits 0-7 go into any third.
// - Opcode 24 complements extension; low 18 instruction bits ignored.
// - Complement of all zeros gives all ones, negative zero.
// - Opcode 25 rotates extension left by low 6 bits plus index, max 63.
// - Rotate time 32 or 36 us by count; each four more add 4 us.
// - Opcode 26 copies accumulator to extension; other fields and repeat ignored.
// - Opcode 27 tests sign bit 23; even selectors jump positive, odd negative, 4-7 return.
// - Sign jump rotates extension left one for selectors 0,1,4,5.
// - Trace control turns any taken sign jump into return jump to zero.
// - Repeated sign jump ends the repeat when the jump is taken.
// - Sign jump 40 us (20 repeat) untaken, 40 taken, 56 for trace or return.
// - Opcode 31 adds address field plus index to accumulator as constant.
// - Opcode 32 adds selected portion of addressed word to accumulator.
// - Opcode 33 adds word to accumulator and writes sum back to that word.
// - Load, store and add take 40 us, 20 us per repeated step.
// - Complement takes 36 us, 16 us per repeated step.
// - Copy and add constant take 32 us, 12 us per repeated step.
// - Nonzero index selector adds that index register to the 15-bit field.
// - Accumulator and extension are 24 bits each.
`default_nettype none
package qax_pkg;
  localparam int CLK_NS = 40;

  // Command word field positions
  localparam int Y_LSB = 0;
  localparam int M_LSB = 15;
  localparam int B_LSB = 18;
  localparam int OP_LSB = 21;
  localparam int R_LSB = 27;

  // Opcodes (octal 22..27, 31..33)
  localparam logic [5:0] OP_LOAD = 6'h12;
  localparam logic [5:0] OP_STORE = 6'h13;
  localparam logic [5:0] OP_COMP = 6'h14;
  localparam logic [5:0] OP_ROT = 6'h15;
  localparam logic [5:0] OP_COPY = 6'h16;
  localparam logic [5:0] OP_JUMP = 6'h17;
  localparam logic [5:0] OP_ADDC = 6'h19;
  localparam logic [5:0] OP_ADD = 6'h1a;
  localparam logic [5:0] OP_ADR = 6'h1b;

  // Register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ACC = 8'h08;
  localparam logic [7:0] A_EXT = 8'h0c;
  localparam logic [7:0] A_PC = 8'h10;
  localparam logic [7:0] A_CTRL = 8'h14;
  localparam logic [7:0] A_IDX = 8'h20;

  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [14:0] RST_PC = 15'h0000;

  // Portion selector codes
  localparam logic [2:0] M_LOW = 3'h1;
  localparam logic [2:0] M_MID = 3'h2;
  localparam logic [2:0] M_HIGH = 3'h3;

  // Operation times in microseconds
  localparam int T_MEM_US = 40;
  localparam int T_MEM_REP_US = 20;
  localparam int T_COMP_US = 36;
  localparam int T_COMP_REP_US = 16;
  localparam int T_XFER_US = 32;
  localparam int T_XFER_REP_US = 12;
  localparam int T_ROT_US = 32;
  localparam int T_ROT_LONG_US = 36;
  localparam int T_ROT_STEP_US = 4;
  localparam int T_JRET_US = 56;
  localparam int T_ADR_US = 60;
  localparam int T_ADR_REP_US = 40;

  // Same times as clock cycles
  localparam logic [11:0] C_MEM = 12'(T_MEM_US * 1000 / CLK_NS);
  localparam logic [11:0] C_MEM_REP = 12'(T_MEM_REP_US * 1000 / CLK_NS);
  localparam logic [11:0] C_COMP = 12'(T_COMP_US * 1000 / CLK_NS);
  localparam logic [11:0] C_COMP_REP = 12'(T_COMP_REP_US * 1000 / CLK_NS);
  localparam logic [11:0] C_XFER = 12'(T_XFER_US * 1000 / CLK_NS);
  localparam logic [11:0] C_XFER_REP = 12'(T_XFER_REP_US * 1000 / CLK_NS);
  localparam logic [11:0] C_ROT = 12'(T_ROT_US * 1000 / CLK_NS);
  localparam logic [11:0] C_ROT_LONG = 12'(T_ROT_LONG_US * 1000 / CLK_NS);
  localparam logic [11:0] C_ROT_STEP = 12'(T_ROT_STEP_US * 1000 / CLK_NS);
  localparam logic [11:0] C_JRET = 12'(T_JRET_US * 1000 / CLK_NS);
  localparam logic [11:0] C_ADR = 12'(T_ADR_US * 1000 / CLK_NS);
  localparam logic [11:0] C_ADR_REP = 12'(T_ADR_REP_US * 1000 / CLK_NS);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DISP = 3'b001,
    S_RD   = 3'b010,
    S_WR   = 3'b011,
    S_WAIT = 3'b100
  } qax_state_e;
endpackage
`default_nettype wire

// File: tb/qax_mem.sv
`timescale 1ns/1ps
`default_nettype none
module qax_mem (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [14:0] mem_addr,
  input  wire logic [23:0] mem_wdata,
  input  wire logic [7:0]  dly,
  output logic [23:0]      mem_rdata,
  output logic             mem_ack
);
  // ****
  // Core storage
  // ****
  logic [23:0] mem [0:32767];
  logic [7:0]  cnt = 8'h00;
  // Quiet bus at start
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 24'h5a5a5a;
  end
  // Ack after dly cycles; data flips away once ack drops so no stale value passes
  always @(posedge pclk) begin
    if (mem_ack) begin
      if (mem_we)
        mem[mem_addr] <= mem_wdata;
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt >= dly) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr];
      cnt       <= 8'h00;
    end else if (mem_req)
      cnt <= cnt + 8'h01;
  end
endmodule
`default_nettype wire

// File: tb/qax_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module qax_exec_tb;
  logic        pclk, presetn, psel, penable, pwrite, sl, pready, pslverr;
  logic        mem_req, mem_we, mem_ack, busy;
  logic [7:0]  paddr, dly;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] mem_addr;
  logic [23:0] mem_wdata, mem_rdata, w, e, acc;
  int          error_cnt = 0;
  int          checks = 0;
  int          a, k, m, p, tk, rt, tr;
  qax_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  qax_mem u_mem (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .dly(dly), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // 40 ns clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ****
  // Helpers
  // ****
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Idle cycle after each transfer keeps psel from being driven twice per step
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    sl = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      error_cnt++;
      end_sim();
    end
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] ad, input string nm, input logic [23:0] ex);
    apb(1'b0, ad, 32'h0);
    chk(nm, rd, {8'h0, ex});
  endtask
  // Busy length sampled on falling edges, away from the design's updates
  task automatic run(input logic [31:0] c, input int cyc, input int st);
    int n;
    apb(1'b1, qax_pkg::A_CMD, c);
    n = 2;
    @(negedge pclk);
    while (busy === 1'b1 && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    chk("time", 32'(n >= cyc - 2 && n <= cyc + 8 * st), 32'h1);
    if (n >= 4000)
      end_sim();
    @(posedge pclk);
  endtask
  function automatic logic [31:0] cmd(input int r, input logic [5:0] op, input int b,
                                      input int mm, input int y);
    return {r[4:0], op, b[2:0], mm[2:0], y[14:0]};
  endfunction
  function automatic logic [23:0] part(input logic [23:0] v, input int mm);
    return (mm < 1 || mm > 3) ? v : (v >> (8 * (mm - 1))) & 24'hff;
  endfunction
  function automatic logic [23:0] ins(input logic [23:0] o, input logic [23:0] n, input int mm);
    return (mm < 1 || mm > 3) ? n :
      (o & ~(24'hff << (8 * (mm - 1)))) | ({16'h0, n[7:0]} << (8 * (mm - 1)));
  endfunction
  function automatic logic [23:0] rotl(input logic [23:0] v, input int n);
    repeat (n) v = {v[22:0], v[23]};
    return v;
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, dly, presetn} = '0;
    void'($urandom(70807));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 6; k++)
      rchk(8'(4 * k), "reset", 24'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'(sl), 32'h1);
    $display("reset test finished");
    apb(1'b1, 8'h2c, 32'h2);
    // Loads through index 3 (value 2), every portion, varied storage delay
    for (m = 0; m < 5; m++) begin
      a = $urandom_range(0, 4000);
      w = 24'($urandom);
      u_mem.mem[a + 2] = w;
      dly <= 8'($urandom_range(0, 4));
      run(cmd(0, qax_pkg::OP_LOAD, 3, m, a), qax_pkg::C_MEM, 1);
      rchk(qax_pkg::A_EXT, "load", part(w, m));
    end
    $display("load test finished");
    e = 24'($urandom);
    apb(1'b1, qax_pkg::A_EXT, {8'h0, e});
    for (m = 0; m < 5; m++) begin
      a = $urandom_range(0, 4000);
      w = 24'($urandom);
      u_mem.mem[a] = w;
      run(cmd(0, qax_pkg::OP_STORE, 0, m, a), qax_pkg::C_MEM, 1);
      chk("store", {8'h0, u_mem.mem[a]}, {8'h0, ins(w, e, m)});
    end
    rchk(qax_pkg::A_EXT, "keep", e);
    apb(1'b1, qax_pkg::A_EXT, 32'h0);
    run(cmd(0, qax_pkg::OP_COMP, 7, 7, 32'h7fff), qax_pkg::C_COMP, 1);
    rchk(qax_pkg::A_EXT, "comp", 24'hffffff);
    run(cmd(1, qax_pkg::OP_COMP, 0, 0, 0), 1300, 2);
    rchk(qax_pkg::A_EXT, "comp2", 24'hffffff);
    $display("store and complement tests finished");
    // Rotations of 5, 7, 15 and 17 places, index adds 2
    for (k = 0; k < 4; k++) begin
      p = 3 + 2 * k + 6 * (k / 2);
      e = 24'($urandom);
      apb(1'b1, qax_pkg::A_EXT, {8'h0, e});
      run(cmd(0, qax_pkg::OP_ROT, 3, 0, p), (k == 0) ? 800 : (k < 3) ? 900 : 1000, 1);
      rchk(qax_pkg::A_EXT, "rot", rotl(e, p + 2));
    end
    acc = 24'($urandom);
    apb(1'b1, qax_pkg::A_ACC, {8'h0, acc});
    run(cmd(5, qax_pkg::OP_COPY, 3, 5, 32'h1234), qax_pkg::C_XFER, 1);
    rchk(qax_pkg::A_EXT, "copy", acc);
    rchk(qax_pkg::A_ACC, "acc", acc);
    $display("rotate and copy tests finished");
    // Every selector on both signs, then trace, then a repeated taken jump
    for (k = 0; k < 19; k++) begin
      m = k % 8;
      tr = (k == 16 || k == 17);
      e = {k[3], 23'($urandom)};
      p = $urandom_range(100, 30000);
      a = $urandom_range(1, 30000);
      tk = ((m % 2) == e[23]);
      rt = tk && (m > 3 || tr);
      apb(1'b1, qax_pkg::A_CTRL, 32'(tr));
      apb(1'b1, qax_pkg::A_EXT, {8'h0, e});
      apb(1'b1, qax_pkg::A_PC, 32'(p));
      run(cmd(3 * (k / 18), qax_pkg::OP_JUMP, 0, m, a), rt ? 1400 : 1000, 1);
      a = tr ? 0 : a;
      apb(1'b0, qax_pkg::A_STAT, 32'h0);
      chk("taken", 32'(rd[1]), 32'(tk));
      rchk(qax_pkg::A_EXT, "shift", (m % 4 < 2) ? rotl(e, 1) : e);
      apb(1'b0, qax_pkg::A_PC, 32'h0);
      if (rt)
        chk("link", {8'h0, u_mem.mem[a]}, 32'(p));
      if (tk)
        chk("pc", rd, 32'(a + rt));
    end
    // Repeated negative test: a miss at full time, a miss at repeat pace, then the jump ends it
    apb(1'b1, qax_pkg::A_EXT, 32'h200000);
    run(cmd(5, qax_pkg::OP_JUMP, 0, 1, a), 2500, 3);
    rchk(qax_pkg::A_EXT, "reprot", 24'h000001);
    apb(1'b0, qax_pkg::A_PC, 32'h0);
    chk("reppc", rd, 32'(a));
    $display("jump test finished");
    // Sums kept small so no end carry arises
    acc = 24'($urandom_range(0, 24'hfffff));
    apb(1'b1, qax_pkg::A_ACC, {8'h0, acc});
    p = $urandom_range(0, 32'h7ff0);
    run(cmd(0, qax_pkg::OP_ADDC, 3, 1, p), qax_pkg::C_XFER, 1);
    acc = acc + 24'(p + 2);
    rchk(qax_pkg::A_ACC, "addc", acc);
    a = $urandom_range(0, 4000);
    for (k = 0; k < 3; k++) begin
      w = 24'($urandom_range(0, 24'hfffff));
      u_mem.mem[a + k + 2] = w;
      acc = acc + w;
    end
    run(cmd(2, qax_pkg::OP_ADD, 3, 0, a), 2000, 3);
    w = 24'($urandom);
    u_mem.mem[a] = w;
    acc = acc + part(w, 2);
    run(cmd(0, qax_pkg::OP_ADD, 0, 2, a), qax_pkg::C_MEM, 1);
    rchk(qax_pkg::A_ACC, "add", acc);
    w = 24'($urandom_range(0, 24'hfffff));
    u_mem.mem[a] = w;
    acc = acc + w;
    run(cmd(0, qax_pkg::OP_ADR, 0, 0, a), qax_pkg::C_ADR, 1);
    chk("adr", {8'h0, u_mem.mem[a]}, {8'h0, acc});
    rchk(qax_pkg::A_ACC, "adracc", acc);
    $display("add test finished");
    end_sim();
  end
endmodule
`default_nettype wire
